/* rtl/vsw_ctrl.sv */
// video switch serial control: two-wire target, 3-wire crossing, selector register
//
// Contract
// R1: power-down low clears the register and forces both outputs off.
// R2: output A selector: 0 off at ground (default), 1-7 pick inputs 1-7.
// R3: output B selector uses the same encoding, default off.
// R4: interface pin low picks 3-wire port, high picks two-wire bus.
// R5: 3-wire frame: chip address, direction one, 5-bit address, 8-bit data, MSB first.
// R6: 3-wire frame runs only when chip address equals the strap pins.
// R7: 3-wire bits sampled on clock rise, latched at the 16th rise.
// R8: host raises select after each 16-clock frame, clock at most 5 MHz.
// R9: two-wire target in fast mode, bus clock up to 400 kHz.
// R10: target address is 00100 then strap hi, strap lo, then direction.
// R11: matching address is acknowledged and served; mismatch gets no answer.
// R12: direction one means read, zero means write.
// R13: write second byte is register address, then data bytes, MSB first.
// R14: every received byte is acknowledged; only a stop ends the transfer.
// R15: address counter steps after each data byte, next byte at new address.
// R16: one-bit counter wraps from 01h back to 00h.
// R17: counter holds last address plus one; current read uses it then steps.
// R18: master ack fetches the next byte; no ack then stop ends sending.
// R19: random read is a dummy write of address then repeated start read.
// R20: data line changes only while the bus clock is low, except start/stop.
// R21: register 00h holds B in bits 6-4, A in bits 2-0; 01h reserved.
// R22: host writes only register 00h and writes zero bits as zero.
// R23: control-mode pin high makes registers unreachable, selectors from pins.
// R24: select rising before the 16th clock drops the frame unchanged.
// R25: a latched selector reaches the outputs at once; the code adds one system clock through the output register.
`timescale 1ns/100ps
module vsw_ctrl
	import vsw_pkg::*;
(
	// system
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// mode and strap pins
	input  wire logic       power_down_n,
	input  wire logic       iface_sel_i2c,
	input  wire logic       parallel_mode,
	input  wire logic       chip_addr_strap_hi,
	input  wire logic       chip_addr_strap_lo,
	// parallel selector pins
	input  wire logic [2:0] par_out_a_sel,
	input  wire logic [2:0] par_out_b_sel,
	// 3-wire link
	input  wire logic       serial_clock,
	input  wire logic       serial_select_n,
	input  wire logic       serial_data_in,
	// two-wire bus
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe,
	// selector outputs
	output logic [2:0]      out_a_source_sel,
	output logic [2:0]      out_b_source_sel,
	output logic            video_out_a_en,
	output logic            video_out_b_en
);

	logic [1:0]    rst_ff_q;
	logic          rst_q_n;
	vsw_pins_t     pin_raw;
	vsw_pins_t     pin_meta_q;
	vsw_pins_t     pin_q;
	vsw_tw_frame_t tw_frame;
	logic          tw_toggle;
	logic          tw_toggle_q;
	logic          tw_event;
	logic          tw_en;
	logic          i2c_en;
	logic [1:0]    strap;
	logic          scl_prev_q;
	logic          sda_prev_q;
	logic          scl_rise;
	logic          scl_fall;
	logic          bus_start;
	logic          bus_stop;
	vsw_i2c_st_t   st_q;
	vsw_byte_t     kind_q;
	logic [3:0]    bit_cnt_q;
	logic [7:0]    rx_sh_q;
	logic [7:0]    tx_sh_q;
	logic          rd_q;
	logic          mack_q;
	logic          addr_ctr_q;
	logic          sda_oe_q;
	logic          i2c_wr;
	logic [7:0]    rd_byte;
	vsw_sel_t      sel_q;
	logic [2:0]    out_a_q;
	logic [2:0]    out_b_q;
	logic          out_a_en_q;
	logic          out_b_en_q;

	// reset release through two flops
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_ff_q <= RST_SYNC_RST;
		end else begin
			rst_ff_q <= {rst_ff_q[0], 1'b1};
		end
	end
	assign rst_q_n = rst_ff_q[1];

	vsw_tw_rx u_tw_rx (
		.serial_clock    (serial_clock),
		.serial_select_n (serial_select_n),
		.serial_data_in  (serial_data_in),
		.rst_sync_n      (rst_q_n),
		.frame_word      (tw_frame),
		.frame_toggle    (tw_toggle)
	);

	// every asynchronous pin but the 3-wire link passes two flops, as does the link's frame toggle
	always_comb begin
		pin_raw               = '0;
		pin_raw.tw_toggle     = tw_toggle;
		pin_raw.par_b         = par_out_b_sel;
		pin_raw.par_a         = par_out_a_sel;
		pin_raw.strap_hi      = chip_addr_strap_hi;
		pin_raw.strap_lo      = chip_addr_strap_lo;
		pin_raw.parallel_mode = parallel_mode;
		pin_raw.iface_sel_i2c = iface_sel_i2c;
		pin_raw.power_down_n  = power_down_n;
		pin_raw.sda           = sda_i;
		pin_raw.scl           = scl_i;
	end

	always_ff @(posedge clk_sys or negedge rst_q_n) begin
		if (!rst_q_n) begin
			pin_meta_q <= PINS_RST;
			pin_q      <= PINS_RST;
		end else begin
			pin_meta_q <= pin_raw;
			pin_q      <= pin_meta_q;
		end
	end

	assign strap  = {pin_q.strap_hi, pin_q.strap_lo};
	assign tw_en  = pin_q.power_down_n & ~pin_q.parallel_mode & ~pin_q.iface_sel_i2c; // [R4] [R23]
	assign i2c_en = pin_q.power_down_n & ~pin_q.parallel_mode & pin_q.iface_sel_i2c;  // [R4] [R23]

	// frame event from the serial clock domain
	always_ff @(posedge clk_sys or negedge rst_q_n) begin
		if (!rst_q_n) begin
			tw_toggle_q <= 1'b0;
		end else begin
			tw_toggle_q <= pin_q.tw_toggle;
		end
	end
	assign tw_event = pin_q.tw_toggle ^ tw_toggle_q;

	// bus edge and condition detection
	always_ff @(posedge clk_sys or negedge rst_q_n) begin
		if (!rst_q_n) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_prev_q <= pin_q.scl;
			sda_prev_q <= pin_q.sda;
		end
	end
	assign scl_rise  = pin_q.scl & ~scl_prev_q;
	assign scl_fall  = ~pin_q.scl & scl_prev_q;
	assign bus_start = pin_q.scl & scl_prev_q & sda_prev_q & ~pin_q.sda;
	assign bus_stop  = pin_q.scl & scl_prev_q & ~sda_prev_q & pin_q.sda;

	// register image as read back
	always_comb begin
		rd_byte = RSVD_VALUE;
		if ({4'h0, addr_ctr_q} == REG_SEL_ADDR) begin
			rd_byte[OUTB_LSB +: SEL_W] = sel_q.out_b; // [R21]
			rd_byte[OUTA_LSB +: SEL_W] = sel_q.out_a; // [R21]
		end
	end

	assign i2c_wr = i2c_en & ~bus_start & ~bus_stop & (st_q == ST_RX) & scl_fall
		& (bit_cnt_q == BYTE_BITS) & (kind_q == BY_DATA);

	// two-wire target; the data line is only pulled low on a detected clock fall, and is also released on start, stop or disable
	always_ff @(posedge clk_sys or negedge rst_q_n) begin
		if (!rst_q_n) begin
			st_q       <= ST_IDLE;
			kind_q     <= BY_ADDR;
			bit_cnt_q  <= BIT_CNT_RST;
			rx_sh_q    <= 8'h00;
			tx_sh_q    <= 8'h00;
			rd_q       <= 1'b0;
			mack_q     <= 1'b0;
			addr_ctr_q <= 1'b0;
			sda_oe_q   <= 1'b0;
		end else if (!i2c_en) begin
			st_q       <= ST_IDLE;
			sda_oe_q   <= 1'b0;
			addr_ctr_q <= 1'b0; // [R1]
		end else if (bus_start) begin
			st_q      <= ST_RX; // [R19]
			kind_q    <= BY_ADDR;
			bit_cnt_q <= BIT_CNT_RST;
			sda_oe_q  <= 1'b0;
		end else if (bus_stop) begin
			st_q     <= ST_IDLE; // [R14]
			sda_oe_q <= 1'b0;
		end else begin
			case (st_q)
				ST_RX: begin
					if (scl_rise && bit_cnt_q != BYTE_BITS) begin
						rx_sh_q   <= {rx_sh_q[6:0], pin_q.sda}; // [R13]
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end else if (scl_fall && bit_cnt_q == BYTE_BITS) begin
						bit_cnt_q <= BIT_CNT_RST;
						case (kind_q)
							BY_ADDR: begin
								if (rx_sh_q[7:1] == {TGT_ADDR_FIXED, strap}) begin // [R10]
									rd_q     <= (rx_sh_q[0] == DIR_READ); // [R12]
									sda_oe_q <= 1'b1; // [R11]
									st_q     <= ST_ACK;
								end else begin
									st_q <= ST_IDLE; // [R11]
								end
							end
							BY_REG: begin
								addr_ctr_q <= rx_sh_q[0]; // [R13]
								sda_oe_q   <= 1'b1; // [R14]
								st_q       <= ST_ACK;
							end
							BY_DATA: begin
								addr_ctr_q <= addr_ctr_q + 1'b1; // [R15] [R16]
								sda_oe_q   <= 1'b1; // [R14]
								st_q       <= ST_ACK;
							end
							default: begin
								st_q <= ST_IDLE;
							end
						endcase
					end
				end
				ST_ACK: begin
					if (scl_fall && rd_q) begin
						tx_sh_q    <= rd_byte; // [R17]
						sda_oe_q   <= ~rd_byte[7]; // [R20]
						addr_ctr_q <= addr_ctr_q + 1'b1; // [R17] [R16]
						bit_cnt_q  <= BIT_CNT_RST;
						st_q       <= ST_TX;
					end else if (scl_fall) begin
						sda_oe_q <= 1'b0;
						kind_q   <= (kind_q == BY_ADDR) ? BY_REG : BY_DATA; // [R13]
						st_q     <= ST_RX;
					end
				end
				ST_TX: begin
					if (scl_fall && bit_cnt_q == TX_LAST_BIT) begin
						sda_oe_q  <= 1'b0;
						bit_cnt_q <= BIT_CNT_RST;
						st_q      <= ST_MACK;
					end else if (scl_fall) begin
						tx_sh_q   <= {tx_sh_q[6:0], 1'b0};
						sda_oe_q  <= ~tx_sh_q[6]; // [R20]
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						mack_q <= (pin_q.sda == ACK_LEVEL);
					end else if (scl_fall && mack_q) begin
						tx_sh_q    <= rd_byte; // [R18]
						sda_oe_q   <= ~rd_byte[7];
						addr_ctr_q <= addr_ctr_q + 1'b1; // [R18] [R16]
						st_q       <= ST_TX;
					end else if (scl_fall) begin
						st_q <= ST_IDLE; // [R18]
					end
				end
				default: begin
					sda_oe_q <= 1'b0;
				end
			endcase
		end
	end

	// selector register; power-down wins over any write
	always_ff @(posedge clk_sys or negedge rst_q_n) begin
		if (!rst_q_n) begin
			sel_q <= SEL_RST;
		end else if (!pin_q.power_down_n) begin
			sel_q <= SEL_RST; // [R1]
		end else if (i2c_wr && {4'h0, addr_ctr_q} == REG_SEL_ADDR) begin
			sel_q.out_b <= rx_sh_q[OUTB_LSB +: SEL_W]; // [R21] [R9]
			sel_q.out_a <= rx_sh_q[OUTA_LSB +: SEL_W]; // [R21]
		end else if (tw_en && tw_event && tw_frame.chip_addr == strap
			&& tw_frame.dir == TW_DIR_WRITE && tw_frame.reg_addr == REG_SEL_ADDR) begin // [R6]
			sel_q.out_b <= tw_frame.data[OUTB_LSB +: SEL_W]; // [R21] [R5]
			sel_q.out_a <= tw_frame.data[OUTA_LSB +: SEL_W];
		end
	end

	// routing to the switch; zero means output grounded
	always_ff @(posedge clk_sys or negedge rst_q_n) begin
		if (!rst_q_n) begin
			out_a_q    <= SEL_OFF;
			out_b_q    <= SEL_OFF;
			out_a_en_q <= 1'b0;
			out_b_en_q <= 1'b0;
		end else if (!pin_q.power_down_n) begin
			out_a_q    <= SEL_OFF; // [R1]
			out_b_q    <= SEL_OFF;
			out_a_en_q <= 1'b0;
			out_b_en_q <= 1'b0;
		end else if (pin_q.parallel_mode) begin
			out_a_q    <= pin_q.par_a; // [R23]
			out_b_q    <= pin_q.par_b;
			out_a_en_q <= (pin_q.par_a != SEL_OFF);
			out_b_en_q <= (pin_q.par_b != SEL_OFF);
		end else begin
			out_a_q    <= sel_q.out_a; // [R2] [R25]
			out_b_q    <= sel_q.out_b; // [R3] [R25]
			out_a_en_q <= (sel_q.out_a != SEL_OFF); // [R2]
			out_b_en_q <= (sel_q.out_b != SEL_OFF); // [R3]
		end
	end

	assign sda_o            = ACK_LEVEL;
	assign sda_oe           = sda_oe_q;
	assign out_a_source_sel = out_a_q;
	assign out_b_source_sel = out_b_q;
	assign video_out_a_en   = out_a_en_q;
	assign video_out_b_en   = out_b_en_q;

endmodule : vsw_ctrl

/* common/vsw_pkg.sv */
// shared constants, carriers and states of the video switch serial control block
package vsw_pkg;

	// two-wire target address, fixed upper part
	localparam logic [4:0] TGT_ADDR_FIXED = 5'h04;
	localparam logic       DIR_READ       = 1'h1;
	localparam logic       ACK_LEVEL      = 1'h0;

	// register addresses
	localparam logic [4:0] REG_SEL_ADDR   = 5'h00;
	localparam logic [4:0] REG_RSVD_ADDR  = 5'h01;

	// selector field layout inside register 00h
	localparam int         SEL_W          = 3;
	localparam int         OUTA_LSB       = 0;
	localparam int         OUTB_LSB       = 4;
	localparam logic [2:0] SEL_OFF        = 3'h0;
	localparam logic [7:0] RSVD_VALUE     = 8'h00;

	// 3-wire frame
	localparam logic [4:0] TW_FRAME_BITS  = 5'h10;
	localparam logic [4:0] TW_LAST_BIT    = 5'h0f;
	localparam logic       TW_DIR_WRITE   = 1'h1;

	// two-wire bit counting
	localparam logic [3:0] BIT_CNT_RST    = 4'h0;
	localparam logic [3:0] BYTE_BITS      = 4'h8;
	localparam logic [3:0] TX_LAST_BIT    = 4'h7;

	// synchroniser reset image: bus lines idle high, everything else low
	localparam logic [13:0] PINS_RST      = 14'h0003;
	localparam logic [1:0]  RST_SYNC_RST  = 2'h0;

	typedef struct packed {
		logic [1:0] chip_addr;
		logic       dir;
		logic [4:0] reg_addr;
		logic [7:0] data;
	} vsw_tw_frame_t;

	typedef struct packed {
		logic [2:0] out_b;
		logic [2:0] out_a;
	} vsw_sel_t;

	typedef struct packed {
		logic       tw_toggle;
		logic [2:0] par_b;
		logic [2:0] par_a;
		logic       strap_hi;
		logic       strap_lo;
		logic       parallel_mode;
		logic       iface_sel_i2c;
		logic       power_down_n;
		logic       sda;
		logic       scl;
	} vsw_pins_t;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_RX   = 5'b00010,
		ST_ACK  = 5'b00100,
		ST_TX   = 5'b01000,
		ST_MACK = 5'b10000
	} vsw_i2c_st_t;

	typedef enum logic [2:0] {
		BY_ADDR = 3'b001,
		BY_REG  = 3'b010,
		BY_DATA = 3'b100
	} vsw_byte_t;

	localparam vsw_sel_t SEL_RST = '{out_b: SEL_OFF, out_a: SEL_OFF};

endpackage : vsw_pkg

/* rtl/vsw_tw_rx.sv */
// 3-wire write-only frame receiver, running on the serial clock
`timescale 1ns/100ps
module vsw_tw_rx
	import vsw_pkg::*;
(
	// link pins
	input  wire logic    serial_clock,
	input  wire logic    serial_select_n,
	input  wire logic    serial_data_in,
	// reset copy from the system domain
	input  wire logic    rst_sync_n,
	// completed frame, toggle marks each one
	output vsw_tw_frame_t frame_word,
	output logic          frame_toggle
);

	logic [4:0]    bit_cnt_q;
	logic [14:0]   shift_q;
	vsw_tw_frame_t frame_q;
	logic          toggle_q;

	// select high clears the count, so an early rise drops the frame
	always_ff @(posedge serial_clock or posedge serial_select_n) begin
		if (serial_select_n) begin
			bit_cnt_q <= 5'h00; // [R24]
		end else if (bit_cnt_q != TW_FRAME_BITS) begin
			bit_cnt_q <= bit_cnt_q + 5'h01;
		end
	end

	always_ff @(posedge serial_clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			shift_q <= 15'h0000;
		end else if (bit_cnt_q != TW_FRAME_BITS) begin
			shift_q <= {shift_q[13:0], serial_data_in}; // [R7] [R5]
		end
	end

	// latch on the 16th rising edge; toggle carries the event across
	always_ff @(posedge serial_clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			frame_q  <= '0;
			toggle_q <= 1'b0;
		end else if (!serial_select_n && bit_cnt_q == TW_LAST_BIT) begin
			frame_q  <= {shift_q, serial_data_in}; // [R7] [R5]
			toggle_q <= ~toggle_q;
		end
	end

	assign frame_word   = frame_q;
	assign frame_toggle = toggle_q;

endmodule : vsw_tw_rx

/* bench/vsw_ctrl_monitor.sv */
// port checker for the video switch serial control block
`timescale 1ns/100ps
module vsw_ctrl_monitor
	import vsw_pkg::*;
(
	// system
	input logic       clk_sys,
	input logic       rst_n,
	// pins
	input logic       power_down_n,
	input logic       iface_sel_i2c,
	input logic       parallel_mode,
	input logic [2:0] par_out_a_sel,
	input logic [2:0] par_out_b_sel,
	input logic       scl_i,
	// outputs
	input logic       sda_oe,
	input logic [2:0] out_a_source_sel,
	input logic [2:0] out_b_source_sel,
	input logic       video_out_a_en,
	input logic       video_out_b_en
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	a_enable_a: assert property (video_out_a_en == (out_a_source_sel != SEL_OFF))
		else $error("output a enable wrong");
	b_enable_a: assert property (video_out_b_en == (out_b_source_sel != SEL_OFF))
		else $error("output b enable wrong");
	pdn_clear_a: assert property (!power_down_n [*5] |-> !video_out_a_en && !video_out_b_en)
		else $error("outputs live in power-down");
	pdn_bus_a: assert property (!power_down_n [*5] |-> !sda_oe)
		else $error("bus driven in power-down");
	wire_quiet_a: assert property (!iface_sel_i2c [*5] |-> !sda_oe)
		else $error("bus driven in 3-wire mode");
	par_quiet_a: assert property (parallel_mode [*5] |-> !sda_oe)
		else $error("bus driven in parallel mode");
	sda_low_a: assert property ($changed(sda_oe) |-> !scl_i)
		else $error("data line moved with clock high");
	par_follow_a: assert property ((parallel_mode && power_down_n && $stable(par_out_a_sel)
		&& $stable(par_out_b_sel)) [*6] |-> out_a_source_sel == par_out_a_sel
		&& out_b_source_sel == par_out_b_sel)
		else $error("selectors not following pins");

	cover property (sda_oe ##1 !sda_oe);
	cover property (out_a_source_sel != SEL_OFF && !parallel_mode);
	cover property (!power_down_n [*5]);
endmodule : vsw_ctrl_monitor

bind vsw_ctrl vsw_ctrl_monitor u_vsw_ctrl_monitor (.clk_sys, .rst_n, .power_down_n,
	.iface_sel_i2c, .parallel_mode, .par_out_a_sel, .par_out_b_sel, .scl_i, .sda_oe,
	.out_a_source_sel, .out_b_source_sel, .video_out_a_en, .video_out_b_en);

/* bench/vsw_host_model.sv */
// host model: 3-wire frames and two-wire bus master
`timescale 1ns/100ps
module vsw_host_model (
	// bus pacing and line level
	input  logic clk_sys,
	input  logic sda_line,
	// two-wire bus
	output logic scl,
	output logic sda_drv,
	// 3-wire link
	output logic serial_clock,
	output logic serial_select_n,
	output logic serial_data_in
);
	localparam int QTR = 13; // 52 cycles a bit, 385 kHz

	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
		serial_clock = 1'b0;
		serial_select_n = 1'b1;
		serial_data_in = 1'b0;
	end

	task automatic wq();
		repeat (QTR) @(posedge clk_sys);
	endtask : wq

	// also a repeated start from clock low
	task automatic start();
		sda_drv <= 1'b1;
		wq();
		scl <= 1'b1;
		wq();
		sda_drv <= 1'b0;
		wq();
		scl <= 1'b0;
		wq();
	endtask : start

	task automatic stop();
		sda_drv <= 1'b0;
		wq();
		scl <= 1'b1;
		wq();
		sda_drv <= 1'b1;
		wq();
	endtask : stop

	// eight bits msb first, then the ack bit; data moves only with clock low
	task automatic xfer(input logic [7:0] tx, input logic ab, output logic [7:0] rx,
		output logic ack);
		logic r;
		for (int i = 8; i >= 0; i--) begin
			sda_drv <= (i == 0) ? ab : tx[i-1];
			wq();
			scl <= 1'b1;
			wq();
			r = sda_line;
			wq();
			scl <= 1'b0;
			wq();
			if (i == 0)
				ack = r;
			else
				rx[i-1] = r;
		end
	endtask : xfer

	// 12 ns link clock, still outside frames; select high after each frame
	task automatic frame(input logic [15:0] w, input int n);
		#3.3;
		serial_select_n = 1'b0;
		for (int i = 15; i > 15 - n; i--) begin
			serial_data_in = w[i];
			#6 serial_clock = 1'b1;
			#6 serial_clock = 1'b0;
		end
		#6 serial_select_n = 1'b1;
		serial_data_in = ~serial_data_in;
	endtask : frame
endmodule : vsw_host_model

/* bench/tb.sv */
// self-checking bench for the video switch serial control block
`timescale 1ns/100ps
module tb;
	logic       clk_sys, rst_n, power_down_n, iface_sel_i2c, parallel_mode;
	logic       chip_addr_strap_hi, chip_addr_strap_lo, scl_i, sda_i, sda_o, sda_oe;
	logic       serial_clock, serial_select_n, serial_data_in, sda_drv, ack;
	logic       video_out_a_en, video_out_b_en;
	logic [2:0] par_out_a_sel, par_out_b_sel, out_a_source_sel, out_b_source_sel;
	logic [7:0] rx, d, aw;
	int         num_errors, num_checks, model_q, seed, k;

	assign sda_i = sda_oe ? sda_o : sda_drv;
	always #25 clk_sys = ~clk_sys;

	vsw_ctrl u_vsw_ctrl (.clk_sys, .rst_n, .power_down_n, .iface_sel_i2c, .parallel_mode,
		.chip_addr_strap_hi, .chip_addr_strap_lo, .par_out_a_sel, .par_out_b_sel,
		.serial_clock, .serial_select_n, .serial_data_in, .scl_i, .sda_i, .sda_o, .sda_oe,
		.out_a_source_sel, .out_b_source_sel, .video_out_a_en, .video_out_b_en);
	vsw_host_model u_host (.clk_sys, .sda_line(sda_i), .scl(scl_i), .sda_drv,
		.serial_clock, .serial_select_n, .serial_data_in);

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic chk_out();
		check({1'b0, out_b_source_sel, 1'b0, out_a_source_sel}, model_q[7:0]);
		check({video_out_b_en, video_out_a_en}, {model_q[6:4] != 0, model_q[2:0] != 0});
	endtask : chk_out

	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : wt

	task automatic put(input logic [7:0] b, input logic ea);
		u_host.xfer(b, 1'b1, rx, ack);
		check({7'h0, ack}, {7'h0, ea});
	endtask : put

	task automatic get(input logic ma, input int exp);
		u_host.xfer(8'hff, ma, rx, ack);
		check(rx, exp[7:0]);
	endtask : get

	task automatic rnd_read();
		u_host.start();
		put(aw, 1'b0);
		put(8'h00, 1'b0);
		u_host.start();
		put(aw | 8'h01, 1'b0);
		get(1'b1, model_q);
		u_host.stop();
	endtask : rnd_read

	task automatic print_verdict();
		if (num_errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict

	initial begin
		#4ms;
		num_errors++;
		print_verdict();
	end

	initial begin
		seed = 32'h59c1;
		clk_sys = 1'b0;
		rst_n = 1'b0;
		power_down_n = 1'b1;
		iface_sel_i2c = 1'b0;
		parallel_mode = 1'b0;
		par_out_a_sel = 3'h0;
		par_out_b_sel = 3'h0;
		k = $random(seed);
		{chip_addr_strap_hi, chip_addr_strap_lo} = k[1:0];
		model_q = 0;
		wt(4);
		rst_n <= 1'b1;
		wt(8);
		chk_out();
		// 3-wire: good, foreign chip address, wrong direction, cut short
		for (int i = 0; i < 12; i++) begin
			k = $random(seed);
			d = k[7:0] & 8'h77;
			u_host.frame({(i % 4 == 1) ? ~{chip_addr_strap_hi, chip_addr_strap_lo} :
				{chip_addr_strap_hi, chip_addr_strap_lo}, i % 4 != 2, 5'h00, d},
				(i % 4 == 3) ? 15 : 16);
			if (i % 4 == 0)
				model_q = d;
			wt(10);
			chk_out();
		end
		iface_sel_i2c <= 1'b1;
		wt(6);
		aw = {5'h04, chip_addr_strap_hi, chip_addr_strap_lo, 1'b0};
		// three data bytes: 00, then 01 ignored, then wrap to 00
		u_host.start();
		put(aw, 1'b0);
		put(8'h00, 1'b0);
		for (int i = 0; i < 3; i++) begin
			k = $random(seed);
			d = k[7:0] & 8'h77;
			put((i == 1) ? 8'h00 : d, 1'b0);
			if (i != 1)
				model_q = d;
		end
		u_host.stop();
		wt(4);
		chk_out();
		// current read starts at 01, master ack steps to 00
		u_host.start();
		put(aw | 8'h01, 1'b0);
		get(1'b0, 0);
		get(1'b1, model_q);
		u_host.stop();
		rnd_read();
		u_host.start();
		put(aw ^ 8'h02, 1'b1);
		u_host.stop();
		// pins take over, bus shut out
		parallel_mode <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			k = $random(seed);
			par_out_a_sel <= k[2:0];
			par_out_b_sel <= k[6:4];
			wt(8);
			check({1'b0, out_b_source_sel, 1'b0, out_a_source_sel},
				{1'b0, k[6:4], 1'b0, k[2:0]});
		end
		u_host.start();
		put(aw, 1'b1);
		u_host.stop();
		parallel_mode <= 1'b0;
		wt(8);
		chk_out();
		power_down_n <= 1'b0;
		wt(8);
		model_q = 0;
		chk_out();
		power_down_n <= 1'b1;
		wt(8);
		rnd_read();
		print_verdict();
	end
endmodule : tb
